// *** rtl/ffq_pkg.sv ***
package ffq_pkg;
	// sizes of the forwarding structures
	localparam int NPORT = 8; // gigabit ports
	localparam int NCLS = 8; // classes per port
	localparam int NMCQ = 4; // multicast queues per port
	localparam int NHND = 16; // frame control handles
	localparam int HW = 4; // handle index width
	localparam int MCQ_D = 4; // entries per multicast queue
	localparam int GRAN_BYTES = 8; // bytes per granule
	localparam int HDR_GRAN = 8; // 64 header bytes in granules
	localparam int RSPQ_DEPTH = 16; // switch response queue words
	// drop thresholds
	localparam int GLB_LIMIT = 12; // handles in use before global drop
	localparam int Q_LIMIT = 6; // logical queue depth before drop
	// memory slot rate against the system clock
	localparam int MEM_MHZ = 133;
	localparam int CLK_MHZ = 200;
	// descriptor area, mirrored in both banks
	localparam logic [11:0] DESC_BASE = 12'h800;
	localparam logic [3:0] TK_RESET = 4'h0;

	typedef struct packed { // one granule from a receive fifo
		logic vld;
		logic [63:0] data;
		logic [3:0] nb;
		logic eof;
		logic good;
	} ffq_rxg_type;
	typedef struct packed { // switch request
		logic [HW-1:0] hnd;
		logic [2:0] port;
		logic [HDR_GRAN-1:0][63:0] hdr;
	} ffq_req_type;
	typedef struct packed { // switch response
		logic [HW-1:0] hnd;
		logic [NPORT-1:0] dst;
		logic uni;
		logic [2:0] cls;
	} ffq_rsp_type;
	typedef struct packed { // one bank command
		logic en;
		logic we;
		logic [11:0] addr;
		logic [63:0] wdata;
	} ffq_mem_type;
	typedef struct packed { // granule towards a transmit fifo
		logic vld;
		logic [2:0] port;
		logic [63:0] data;
		logic [3:0] nb;
		logic eof;
	} ffq_txg_type;
	typedef struct packed { // frame control handle contents
		logic [7:0] ngran;
		logic [3:0] lastnb;
		logic [NPORT-1:0] pend;
		logic [2:0] cls;
	} ffq_fcb_type;
	typedef struct packed { // multicast queue entry
		logic [HW-1:0] hnd;
		logic [2:0] cls;
	} ffq_mce_type;
	typedef struct packed { // receive side per port
		logic has;
		logic req;
		logic [HW-1:0] hnd;
		logic [7:0] gidx;
	} ffq_prx_type;
	typedef struct packed { // port control per port
		logic act;
		logic [HW-1:0] hnd;
		logic [7:0] gidx;
	} ffq_ptx_type;
	typedef struct packed { // read in flight
		logic vld;
		logic [2:0] port;
		logic bank;
		logic [3:0] nb;
		logic eof;
	} ffq_rd_type;
	typedef struct packed { // whole engine state
		logic [8:0] acc;
		logic [3:0] tk;
		logic [NHND-1:0] used;
		ffq_fcb_type [NHND-1:0] fcb;
		logic [NHND-1:0][HW-1:0] nxt;
		logic [NPORT-1:0][NCLS-1:0][HW-1:0] uh;
		logic [NPORT-1:0][NCLS-1:0][HW-1:0] ut;
		logic [NPORT-1:0][NCLS-1:0] uv;
		logic [NPORT-1:0][NCLS-1:0][3:0] occ;
		ffq_mce_type [NPORT-1:0][NMCQ-1:0][MCQ_D-1:0] mq;
		logic [NPORT-1:0][NMCQ-1:0][1:0] mrd;
		logic [NPORT-1:0][NMCQ-1:0][1:0] mwr;
		logic [NPORT-1:0][NMCQ-1:0][2:0] mcnt;
		ffq_prx_type [NPORT-1:0] prx;
		logic [NPORT-1:0][HDR_GRAN-1:0][63:0] hdr;
		ffq_ptx_type [NPORT-1:0] ptx;
		logic [NPORT-1:0] rel;
		logic [NPORT-1:0][HW-1:0] relh;
		logic [2:0] rrq;
		logic [2:0] rrr;
		logic sv;
		ffq_req_type sreq;
		ffq_mem_type ma;
		ffq_mem_type mb;
		ffq_rd_type rd1;
		ffq_rd_type rd2;
		ffq_txg_type txo;
	} ffq_st_type;
endpackage : ffq_pkg

// *** rtl/ffq_engine.sv ***
// What this block does
// - every arriving frame gets a control handle
// - receive turn moves one granule per port
// - switch request only after good stored frame
// - arbitrate switch requests, one at a time
// - request carries first 64 frame bytes
// - unicast drop uses global and queue occupancy
// - kept unicast appended to port class list
// - room in transmit fifo fetches head frame
// - transmit turn moves one granule from memory
// - unicast end read requests handle release
// - global multicast drop releases whole frame
// - selective multicast drop keeps handle for others
// - kept multicast entry into pair-class queue
// - unicast list plus multicast queue one queue
// - multicast release after all ports read end
// - two banks, one operation each per tick
// - transmit ports take turns, one bank read per tick
// - granules alternate bank a then b
// - each frame starts in bank a
// - search data written to both banks

// response queue, flip-flop storage
module ffq_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem; // storage words
		logic [AW-1:0] wp; // write index
		logic [AW-1:0] rp; // read index
		logic [AW:0] cnt; // words held
	} ffq_fifo_st_type;
	ffq_fifo_st_type s_r;
	ffq_fifo_st_type s_nxt;
	logic push;
	logic pop;

	// full stalls the writer, so the source really sees back-pressure
	always_comb begin
		s_nxt = s_r;
		in_ready = s_r.cnt != (AW+1)'(DEPTH);
		out_valid = s_r.cnt != '0;
		out_data = s_r.mem[s_r.rp]; // oldest word first
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data;
			s_nxt.wp = s_r.wp + AW'(1);
		end
		if (pop) begin
			s_nxt.rp = s_r.rp + AW'(1);
		end
		s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : ffq_fifo

// frame engine top
module ffq_engine import ffq_pkg::*; (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire ffq_rxg_type [NPORT-1:0] rx_i,
	output logic [NPORT-1:0] rx_ready,
	output ffq_req_type sw_req,
	output logic sw_req_valid,
	input wire logic sw_req_ready,
	input wire ffq_rsp_type sw_rsp,
	input wire logic sw_rsp_valid,
	output logic sw_rsp_ready,
	output ffq_mem_type mem_a,
	output ffq_mem_type mem_b,
	input wire logic [63:0] mem_a_rdata,
	input wire logic [63:0] mem_b_rdata,
	input wire logic [NPORT-1:0] tx_room,
	output ffq_txg_type tx_o
);
	ffq_st_type s_r; // all engine state
	ffq_st_type s_nxt; // its next value
	logic tick; // memory slot enable
	logic rxph; // receive half of the slot pair
	logic [2:0] sp; // port owning this slot
	logic [HW-1:0] freeh; // lowest free handle
	logic free_ok; // some handle is free
	logic take; // receive granule accepted
	logic rsp_pop; // response consumed
	logic f_vld; // response queue not empty
	ffq_rsp_type f_out; // oldest response
	ffq_rsp_type r; // response under decision
	logic [HW-1:0] h; // handle being worked on
	logic [7:0] g; // granule index being moved
	logic last; // end granule of the frame
	logic glb; // global buffer pressure
	logic done; // unicast already placed
	logic found; // schedulable class seen
	logic sel_uc; // head comes from unicast list
	logic [2:0] sel_c; // chosen class
	logic [1:0] q; // multicast queue index
	logic [NPORT-1:0] kept; // destinations that keep the frame
	int cnt; // handles in use
	int ix; // rotating arbiter index

	// response queue in front of the decision logic
	ffq_fifo #(
		.WIDTH($bits(ffq_rsp_type)),
		.DEPTH(RSPQ_DEPTH)
	) u_rspq (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.in_valid(sw_rsp_valid),
		.in_ready(sw_rsp_ready),
		.in_data(sw_rsp),
		.out_valid(f_vld),
		.out_ready(rsp_pop),
		.out_data(f_out)
	);

	// next-state logic for the whole engine
	always_comb begin
		s_nxt = s_r;
		tick = 1'b0;
		rx_ready = '0;
		take = 1'b0;
		rsp_pop = 1'b0;
		r = f_out;
		h = '0;
		g = '0;
		last = 1'b0;
		glb = 1'b0;
		done = 1'b0;
		found = 1'b0;
		sel_uc = 1'b0;
		sel_c = '0;
		q = '0;
		kept = '0;
		cnt = 0;
		ix = 0;
		freeh = '0;
		free_ok = 1'b0;
		// memory commands last one cycle only
		s_nxt.ma = '0;
		s_nxt.mb = '0;
		s_nxt.rd1 = '0;
		s_nxt.rd2 = s_r.rd1;
		s_nxt.txo.vld = 1'b0;

		// fractional divider: 133 ticks in every 200 clocks
		s_nxt.acc = s_r.acc + 9'(MEM_MHZ);
		if (s_nxt.acc >= 9'(CLK_MHZ)) begin
			tick = 1'b1;
			s_nxt.acc = s_nxt.acc - 9'(CLK_MHZ);
		end
		if (tick) begin
			s_nxt.tk = s_r.tk + 4'h1;
		end
		// slot pair per port: receive half, then transmit half
		sp = s_r.tk[3:1];
		rxph = ~s_r.tk[0];

		// handle pool: lowest free index and usage count
		for (int i = NHND - 1; i >= 0; i--) begin
			if (!s_r.used[i]) begin
				freeh = HW'(i);
				free_ok = 1'b1;
			end
		end
		for (int i = 0; i < NHND; i++) begin
			cnt = cnt + int'(s_r.used[i]);
		end
		glb = cnt > GLB_LIMIT;

		// receive turn; waits while the header is still unsent
		rx_ready[sp] = tick && rxph && !s_r.prx[sp].req && (s_r.prx[sp].has || free_ok);
		take = rx_ready[sp] && rx_i[sp].vld;
		if (take) begin
			// a new frame takes the lowest free handle at frame start
			h = s_r.prx[sp].has ? s_r.prx[sp].hnd : freeh;
			g = s_r.prx[sp].has ? s_r.prx[sp].gidx : 8'h00;
			if (!s_r.prx[sp].has) begin
				s_nxt.used[h] = 1'b1;
				s_nxt.prx[sp].has = 1'b1;
				s_nxt.prx[sp].hnd = h;
				s_nxt.hdr[sp] = '0; // short frames pad with zeros
			end
			// even granules to bank a, odd to bank b
			if (!g[0]) begin
				s_nxt.ma = {1'b1, 1'b1, {1'b0, h, g[7:1]}, rx_i[sp].data};
			end else begin
				s_nxt.mb = {1'b1, 1'b1, {1'b0, h, g[7:1]}, rx_i[sp].data};
			end
			// keep the first 64 bytes for the search
			if (g < 8'(HDR_GRAN)) begin
				s_nxt.hdr[sp][g[2:0]] = rx_i[sp].data;
			end
			s_nxt.prx[sp].gidx = g + 8'h01;
			if (rx_i[sp].eof) begin
				s_nxt.prx[sp].has = 1'b0;
				s_nxt.prx[sp].gidx = 8'h00; // next frame restarts in bank a
				if (rx_i[sp].good) begin
					s_nxt.prx[sp].req = 1'b1;
					s_nxt.fcb[h].ngran = g + 8'h01;
					s_nxt.fcb[h].lastnb = rx_i[sp].nb;
				end else begin
					s_nxt.used[h] = 1'b0; // bad frame gives its handle back
				end
			end
		end

		// responses use receive slots the port leaves idle, both banks free
		rsp_pop = tick && rxph && !take && f_vld;
		if (rsp_pop) begin
			// mirror the result in both banks
			s_nxt.ma = {1'b1, 1'b1, DESC_BASE | 12'(r.hnd), 64'(r)};
			s_nxt.mb = {1'b1, 1'b1, DESC_BASE | 12'(r.hnd), 64'(r)};
			q = r.cls[2:1]; // one multicast queue per class pair
			for (int p = 0; p < NPORT; p++) begin
				if (r.dst[p] && !glb && s_r.occ[p][r.cls] < 4'(Q_LIMIT)) begin
					if (r.uni && !done) begin
						// append to the tail of the class list
						done = 1'b1;
						kept[p] = 1'b1;
						if (s_r.uv[p][r.cls]) begin
							s_nxt.nxt[s_r.ut[p][r.cls]] = r.hnd;
						end else begin
							s_nxt.uh[p][r.cls] = r.hnd;
						end
						s_nxt.ut[p][r.cls] = r.hnd;
						s_nxt.uv[p][r.cls] = 1'b1;
						s_nxt.occ[p][r.cls] = s_r.occ[p][r.cls] + 4'h1;
					end else if (!r.uni && s_r.mcnt[p][q] < 3'(MCQ_D)) begin
						// physical queue entry for this destination
						kept[p] = 1'b1;
						s_nxt.mq[p][q][s_r.mwr[p][q]] = {r.hnd, r.cls};
						s_nxt.mwr[p][q] = s_r.mwr[p][q] + 2'h1;
						s_nxt.mcnt[p][q] = s_r.mcnt[p][q] + 3'h1;
						s_nxt.occ[p][r.cls] = s_r.occ[p][r.cls] + 4'h1;
					end
				end
			end
			s_nxt.fcb[r.hnd].pend = kept;
			s_nxt.fcb[r.hnd].cls = r.cls;
			// dropped everywhere: frame gone, handle free again
			if (kept == '0) begin
				s_nxt.used[r.hnd] = 1'b0;
			end
		end

		// transmit turn; one port per tick, so one bank read per tick
		if (tick && !rxph) begin
			if (s_r.ptx[sp].act) begin
				h = s_r.ptx[sp].hnd;
				g = s_r.ptx[sp].gidx;
				last = g == s_r.fcb[h].ngran - 8'h01;
				// end granule waits until the last release went out
				if (!(last && s_r.rel[sp])) begin
					// bank follows granule parity, a first
					if (!g[0]) begin
						s_nxt.ma = {1'b1, 1'b0, {1'b0, h, g[7:1]}, 64'h0};
					end else begin
						s_nxt.mb = {1'b1, 1'b0, {1'b0, h, g[7:1]}, 64'h0};
					end
					s_nxt.rd1 = {1'b1, sp, g[0], last ? s_r.fcb[h].lastnb : 4'(GRAN_BYTES), last};
					s_nxt.ptx[sp].gidx = g + 8'h01;
					if (last) begin
						s_nxt.ptx[sp].act = 1'b0;
						s_nxt.rel[sp] = 1'b1;
						s_nxt.relh[sp] = h;
					end
				end
			end else if (tx_room[sp]) begin
				// highest class wins; list and queue form one logical queue
				for (int c = 0; c < NCLS; c++) begin
					if (s_r.uv[sp][c]) begin
						found = 1'b1;
						sel_uc = 1'b1;
						sel_c = 3'(c);
					end else if (s_r.mcnt[sp][c/2] != 3'h0 && s_r.mq[sp][c/2][s_r.mrd[sp][c/2]].cls == 3'(c)) begin
						found = 1'b1;
						sel_uc = 1'b0;
						sel_c = 3'(c);
					end
				end
				if (found) begin
					q = sel_c[2:1];
					if (sel_uc) begin
						// pop the list head
						h = s_r.uh[sp][sel_c];
						if (s_r.uh[sp][sel_c] == s_r.ut[sp][sel_c]) begin
							s_nxt.uv[sp][sel_c] = 1'b0;
						end else begin
							s_nxt.uh[sp][sel_c] = s_r.nxt[h];
						end
					end else begin
						// pop the multicast queue head
						h = s_r.mq[sp][q][s_r.mrd[sp][q]].hnd;
						s_nxt.mrd[sp][q] = s_r.mrd[sp][q] + 2'h1;
						s_nxt.mcnt[sp][q] = s_r.mcnt[sp][q] - 3'h1;
					end
					s_nxt.occ[sp][sel_c] = s_r.occ[sp][sel_c] - 4'h1;
					s_nxt.ptx[sp] = {1'b1, h, 8'h00};
				end
			end
		end

		// release arbiter: rotating, one per clock
		found = 1'b0;
		for (int i = 0; i < NPORT; i++) begin
			ix = (int'(s_r.rrr) + i) % NPORT;
			if (!found && s_r.rel[ix]) begin
				found = 1'b1;
				h = s_r.relh[ix];
				s_nxt.rel[ix] = 1'b0;
				s_nxt.rrr = 3'(ix + 1);
				s_nxt.fcb[h].pend[ix] = 1'b0;
				// handle returns once the last reader is done
				if (s_nxt.fcb[h].pend == '0) begin
					s_nxt.used[h] = 1'b0;
				end
			end
		end

		// switch request arbiter: one request outstanding at a time
		if (s_r.sv && sw_req_ready) begin
			s_nxt.sv = 1'b0;
		end
		found = 1'b0;
		if (!s_r.sv) begin
			for (int i = 0; i < NPORT; i++) begin
				ix = (int'(s_r.rrq) + i) % NPORT;
				if (!found && s_r.prx[ix].req) begin
					found = 1'b1;
					s_nxt.sv = 1'b1;
					s_nxt.sreq = {s_r.prx[ix].hnd, 3'(ix), s_r.hdr[ix]};
					s_nxt.prx[ix].req = 1'b0;
					s_nxt.rrq = 3'(ix + 1);
				end
			end
		end

		// read data returns one cycle after the command
		if (s_r.rd2.vld) begin
			s_nxt.txo = {1'b1, s_r.rd2.port, s_r.rd2.bank ? mem_b_rdata : mem_a_rdata, s_r.rd2.nb, s_r.rd2.eof};
		end
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// registered outputs
	assign mem_a = s_r.ma;
	assign mem_b = s_r.mb;
	assign sw_req = s_r.sreq;
	assign sw_req_valid = s_r.sv;
	assign tx_o = s_r.txo;
endmodule : ffq_engine

// *** tb/ffq_engine_assertions.sv ***
module ffq_engine_assertions import ffq_pkg::*; (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire ffq_rxg_type [NPORT-1:0] rx_i,
	input wire logic [NPORT-1:0] rx_ready,
	input wire ffq_req_type sw_req,
	input wire logic sw_req_valid,
	input wire logic sw_req_ready,
	input wire ffq_mem_type mem_a,
	input wire ffq_mem_type mem_b,
	input wire logic [63:0] mem_a_rdata,
	input wire ffq_txg_type tx_o
);
	logic [NPORT-1:0] take; // granule taken
	logic [NPORT-1:0][7:0] gk_r; // granule index
	logic [NPORT-1:0] done_r; // good frame, request owed
	logic odd; // goes to bank b
	logic [6:0] half; // bank row
	logic rda; // read on a
	logic rdb; // read on b
	assign rda = mem_a.en && !mem_a.we;
	assign rdb = mem_b.en && !mem_b.we;
	// one port takes per tick, so a scan is enough
	always_comb begin
		odd = 1'b0;
		half = 7'h00;
		for (int p = 0; p < NPORT; p++) begin
			take[p] = rx_ready[p] && rx_i[p].vld;
			if (take[p]) begin
				odd = gk_r[p][0];
				half = gk_r[p][7:1];
			end
		end
	end
	// clear first: a new frame can arrive while the port's request waits
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			gk_r <= '0;
			done_r <= '0;
		end else begin
			if (sw_req_valid && sw_req_ready)
				done_r[sw_req.port] <= 1'b0;
			for (int p = 0; p < NPORT; p++) begin
				if (take[p]) begin
					gk_r[p] <= rx_i[p].eof ? 8'h00 : gk_r[p] + 8'h01;
					if (rx_i[p].eof && rx_i[p].good)
						done_r[p] <= 1'b1;
				end
			end
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	req_hold_a: assert property (sw_req_valid && !sw_req_ready |=> sw_req_valid && $stable(sw_req))
		else $error("request changed before taken");
	req_once_a: assert property (sw_req_valid && sw_req_ready |=> !sw_req_valid)
		else $error("request not dropped");
	req_good_a: assert property (sw_req_valid |-> done_r[sw_req.port])
		else $error("request without good frame");
	bank_a_a: assert property (|take && !odd |=> mem_a.en && mem_a.we && mem_a.addr[6:0] == $past(half))
		else $error("even granule not in bank a");
	bank_b_a: assert property (|take && odd |=> mem_b.en && mem_b.we && mem_b.addr[6:0] == $past(half))
		else $error("odd granule not in bank b");
	desc_dual_a: assert property (mem_a.en && mem_a.we && mem_a.addr[11] |->
		mem_b.en && mem_b.we && mem_b.addr == mem_a.addr && mem_b.wdata == mem_a.wdata)
		else $error("descriptor not in both banks");
	read_data_a: assert property (rda ##1 1 |=> tx_o.vld && tx_o.data == $past(mem_a_rdata))
		else $error("read data not forwarded");
	tx_cause_a: assert property (tx_o.vld |-> $past(rda, 2) || $past(rdb, 2))
		else $error("granule without read");
	tx_size_a: assert property (tx_o.vld && !tx_o.eof |-> tx_o.nb == 4'h8)
		else $error("short middle granule");
	cover property (sw_req_valid && sw_req_ready);
	cover property (tx_o.vld && tx_o.eof);
	cover property (mem_a.en && mem_a.we && mem_a.addr[11]);
endmodule : ffq_engine_assertions

bind ffq_engine ffq_engine_assertions chk (.clk_sys(clk_sys), .resetn(resetn), .rx_i(rx_i),
	.rx_ready(rx_ready), .sw_req(sw_req), .sw_req_valid(sw_req_valid), .sw_req_ready(sw_req_ready),
	.mem_a(mem_a), .mem_b(mem_b), .mem_a_rdata(mem_a_rdata), .tx_o(tx_o));

// *** tb/ffq_partner.sv ***
module ffq_partner import ffq_pkg::*; (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [3:0] slow,
	input wire ffq_mem_type mem_a,
	input wire ffq_mem_type mem_b,
	output logic [63:0] mem_a_rdata,
	output logic [63:0] mem_b_rdata,
	input wire ffq_req_type sw_req,
	input wire logic sw_req_valid,
	output logic sw_req_ready,
	output ffq_rsp_type sw_rsp,
	output logic sw_rsp_valid,
	input wire logic sw_rsp_ready
);
	logic [63:0] ba [4096]; // bank a
	logic [63:0] bb [4096]; // bank b
	logic [3:0] dly; // cycles before accepting
	ffq_rsp_type q [$]; // results not yet taken
	// idle read lines toggle so stale data never matches
	always @(posedge clk_sys) begin
		if (mem_a.en && mem_a.we)
			ba[mem_a.addr] <= mem_a.wdata;
		if (mem_b.en && mem_b.we)
			bb[mem_b.addr] <= mem_b.wdata;
		if (!resetn) begin
			mem_a_rdata <= '0;
			mem_b_rdata <= '0;
		end else begin
			mem_a_rdata <= (mem_a.en && !mem_a.we) ? ba[mem_a.addr] : ~mem_a_rdata;
			mem_b_rdata <= (mem_b.en && !mem_b.we) ? bb[mem_b.addr] : ~mem_b_rdata;
		end
	end
	// lookup stand-in: result fields ride in the first granule
	always @(posedge clk_sys) begin
		if (!resetn) begin
			sw_req_ready <= 1'b0;
			sw_rsp_valid <= 1'b0;
			sw_rsp <= '0;
			dly <= 4'h0;
			q.delete();
		end else begin
			if (sw_rsp_valid && sw_rsp_ready)
				void'(q.pop_front());
			if (sw_req_valid && sw_req_ready)
				q.push_back({sw_req.hnd, sw_req.hdr[0][15:8], sw_req.hdr[0][16], sw_req.hdr[0][26:24]});
			if (sw_req_valid && !sw_req_ready)
				dly <= (dly == 4'h0) ? slow : dly - 4'h1;
			sw_req_ready <= sw_req_valid && !sw_req_ready && dly == 4'h0;
			sw_rsp_valid <= q.size() != 0;
			sw_rsp <= (q.size() != 0) ? q[0] : ~sw_rsp;
		end
	end
endmodule : ffq_partner

// *** tb/test_ffq_engine.sv ***
module test_ffq_engine import ffq_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	ffq_rxg_type [NPORT-1:0] rx_i = '0;
	logic [NPORT-1:0] tx_room = 8'hFF;
	logic [3:0] slow = 4'h3; // stalls the lookup side
	logic [NPORT-1:0] rx_ready;
	ffq_req_type sw_req;
	logic sw_req_valid;
	logic sw_req_ready;
	ffq_rsp_type sw_rsp;
	logic sw_rsp_valid;
	logic sw_rsp_ready;
	ffq_mem_type mem_a;
	ffq_mem_type mem_b;
	logic [63:0] mem_a_rdata;
	logic [63:0] mem_b_rdata;
	ffq_txg_type tx_o;
	int failures = 0;
	int checks_done = 0;
	int ndesc = 0; // results stored
	logic [31:0] seed = 32'hA6A5;
	logic [515:0] exq [NPORT][$]; // {count, header} per source
	logic [68:0] transmit_class_queue [NPORT][$]; // {eof, nb, data} per sink
	initial forever #2.5 clk_sys = ~clk_sys;
	ffq_engine uut (.clk_sys(clk_sys), .resetn(resetn), .rx_i(rx_i), .rx_ready(rx_ready), .sw_req(sw_req),
		.sw_req_valid(sw_req_valid), .sw_req_ready(sw_req_ready), .sw_rsp(sw_rsp), .sw_rsp_valid(sw_rsp_valid),
		.sw_rsp_ready(sw_rsp_ready), .mem_a(mem_a), .mem_b(mem_b), .mem_a_rdata(mem_a_rdata),
		.mem_b_rdata(mem_b_rdata), .tx_room(tx_room), .tx_o(tx_o));
	ffq_partner far (.clk_sys(clk_sys), .resetn(resetn), .slow(slow), .mem_a(mem_a), .mem_b(mem_b),
		.mem_a_rdata(mem_a_rdata), .mem_b_rdata(mem_b_rdata), .sw_req(sw_req), .sw_req_valid(sw_req_valid),
		.sw_req_ready(sw_req_ready), .sw_rsp(sw_rsp), .sw_rsp_valid(sw_rsp_valid), .sw_rsp_ready(sw_rsp_ready));
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd
	function automatic int pend();
		int s;
		s = 0;
		foreach (transmit_class_queue[i]) s += transmit_class_queue[i].size() + exq[i].size();
		return s;
	endfunction : pend
	task automatic bad(input string m);
		failures++;
		$display("Error %0t %s", $time, m);
	endtask : bad
	task automatic chk_req(input logic [515:0] e);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < HDR_GRAN; i++)
			if (i < e[515:512] && sw_req.hdr[i] !== e[i*64 +: 64]) ok = 1'b0;
		checks_done++;
		if (!ok) bad("request header");
	endtask : chk_req
	task automatic chk_tx(input logic [68:0] e);
		checks_done++;
		if ({tx_o.eof, tx_o.nb, tx_o.data} !== e) bad("transmit granule");
	endtask : chk_tx
	// one frame on port p; tgt lists sinks that should keep it
	task automatic send(input int p, input int n, input logic [7:0] dst, input logic uni, input logic [2:0] cls,
		input logic good, input logic [7:0] tgt, input logic front);
		logic [63:0] g [$];
		logic [515:0] h;
		logic [3:0] lnb;
		lnb = 4'(rnd() % 8 + 1);
		h = '0;
		for (int k = 0; k < n; k++) begin
			g.push_back({rnd(), rnd()});
			if (k == 0) g[0][26:8] = {cls, 7'h00, uni, dst};
			if (k < 8) h[k*64 +: 64] = g[k];
		end
		h[515:512] = 4'(n < 8 ? n : 8);
		for (int k = 0; k < n; k++) begin
			@(negedge clk_sys);
			rx_i[p] = {1'b1, g[k], k == n - 1 ? lnb : 4'h8, k == n - 1, good};
			#1;
			while (!rx_ready[p]) begin
				@(negedge clk_sys);
				#1;
			end
		end
		@(negedge clk_sys);
		rx_i[p].vld = 1'b0;
		if (good) exq[p].push_back(h);
		for (int d = 0; d < NPORT; d++)
			for (int k = 0; k < n && tgt[d]; k++)
				if (front) transmit_class_queue[d].push_front({n - 1 - k == n - 1, n - 1 - k == n - 1 ? lnb : 4'h8, g[n - 1 - k]});
				else transmit_class_queue[d].push_back({k == n - 1, k == n - 1 ? lnb : 4'h8, g[k]});
	endtask : send
	task automatic settle(input int d, input logic drain);
		int t;
		t = 0;
		while ((ndesc < d || drain && pend() != 0) && t < 20000) begin
			@(negedge clk_sys);
			t++;
		end
		if (t == 20000) bad("stalled");
	endtask : settle
	task automatic conclude();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude
	// watcher: oldest note against each result
	always @(negedge clk_sys) begin
		if (sw_req_valid && sw_req_ready) begin
			if (exq[sw_req.port].size() != 0) chk_req(exq[sw_req.port].pop_front());
			else bad("unexpected request");
		end
		if (tx_o.vld) begin
			if (transmit_class_queue[tx_o.port].size() != 0) chk_tx(transmit_class_queue[tx_o.port].pop_front());
			else bad("unexpected granule");
		end
		if (mem_a.en && mem_a.we && mem_a.addr[11]) ndesc++;
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		bad("watchdog");
		conclude();
	end
	initial begin
		repeat (10) @(negedge clk_sys);
		resetn = 1'b1;
		@(negedge clk_sys);
		checks_done++;
		if (sw_rsp_ready !== 1'b1 || sw_req_valid !== 1'b0) bad("reset state");
		for (int i = 0; i < NPORT; i++) begin
			fork
				automatic int j = i;
				send(j, j + 2, 8'(1 << ((j + 1) % 8)), 1'b1, 3'(j), 1'b1, 8'(1 << ((j + 1) % 8)), 1'b0);
			join_none
		end
		wait fork;
		send(0, 3, 8'h02, 1'b1, 3'h0, 1'b0, 8'h00, 1'b0);
		send(0, 1, 8'h02, 1'b1, 3'h0, 1'b1, 8'h02, 1'b0);
		settle(9, 1'b1);
		$display("test basic done");
		tx_room = 8'h00;
		for (int i = 0; i <= Q_LIMIT; i++)
			send(0, 3, 8'h10, 1'b1, 3'h2, 1'b1, i < Q_LIMIT ? 8'h10 : 8'h00, 1'b0);
		send(1, 2, 8'h30, 1'b0, 3'h2, 1'b1, 8'h20, 1'b0);
		send(1, 4, 8'h10, 1'b1, 3'h6, 1'b1, 8'h10, 1'b1);
		settle(18, 1'b0);
		tx_room = 8'hFF;
		settle(18, 1'b1);
		$display("test queues done");
		tx_room = 8'h00;
		for (int i = 0; i < GLB_LIMIT; i++)
			send(i % 4, 1, 8'(1 << (i % 6)), 1'b1, 3'(i / 6), 1'b1, 8'(1 << (i % 6)), i >= 6);
		// all twelve decided first, else the pool overflow could catch a late one
		settle(30, 1'b0);
		send(5, 1, 8'hC0, 1'b0, 3'h7, 1'b1, 8'h00, 1'b0);
		settle(31, 1'b0);
		tx_room = 8'hFF;
		settle(31, 1'b1);
		$display("test global drop done");
		conclude();
	end
endmodule : test_ffq_engine
